// [rtl/mcece_encoder.sv]
`timescale 1ns/1ps
`include "mcece_defs.svh"
// Operation
// [RULE_01] log 16-bit code, set entry flag
// [RULE_02] optional model code stored beside code
// [RULE_03] code alone classifies the error
// [RULE_04] software reads code only when flagged
// [RULE_05] empty bank holds all-zero code
// [RULE_06] unclassified error logs code one
// [RULE_07] microcode rom parity logs code two
// [RULE_08] external bus-init logs code three
// [RULE_09] bus-init needs strap and enable bit
// [RULE_10] lockstep mismatch four, internal parity five
// [RULE_11] handler range violation logs code six
// [RULE_12] timer and io faults fixed codes
// [RULE_13] internal unclassified: prefix, nonzero low part
// [RULE_14] generic cache: prefix, filter, level
// [RULE_15] tlb and cache compound layouts
// [RULE_16] memory controller and extended memory layouts
// [RULE_17] bus error layout with bit 11
// [RULE_18] filter bit clear for normal filtering
// [RULE_19] filter bit set when filtering activates
// [RULE_20] post first few corrections per line
// [RULE_21] uncorrected events never filtered
// [RULE_22] software ignores filter bit if uncorrected
// [RULE_23] transaction kind encodings, generic fallback
// [RULE_24] hierarchy level encodings, generic eleven
// [RULE_25] code and flag update together
module mcece_encoder
  import mcece_pkg::*;
(
  input  wire logic                     core_clk_i,
  input  wire logic                     rst_n_i,
  // apb slave
  input  wire logic                     psel_i,
  input  wire logic                     penable_i,
  input  wire logic                     pwrite_i,
  input  wire logic [`MCECE_ADDR_W-1:0] paddr_i,
  input  wire logic [31:0]              pwdata_i,
  output logic      [31:0]              prdata_o,
  output logic                          pready_o,
  output logic                          pslverr_o,
  // internal detectors
  input  wire logic                     err_valid_i,
  input  wire mcece_class_type          err_class_i,
  input  wire logic                     uncorrected_flag_i,
  input  wire logic [`MCECE_TAG_W-1:0]  line_tag_i,
  input  wire logic [1:0]               transaction_kind_field_i,
  input  wire logic [1:0]               hierarchy_level_field_i,
  input  wire logic [3:0]               request_kind_field_i,
  input  wire logic [2:0]               memory_request_field_i,
  input  wire logic [3:0]               channel_number_field_i,
  input  wire logic [1:0]               participation_field_i,
  input  wire logic                     timeout_i,
  input  wire logic [1:0]               memory_or_io_field_i,
  input  wire logic [9:0]               internal_detail_i,
  input  wire logic [15:0]              model_code_i,
  // pins
  input  wire logic                     bus_init_input_i,
  input  wire logic                     strap_bus_init_observe_i,
  output logic                          mc_exception_o
);
  // ---------------------------------------------
  // state
  // ---------------------------------------------
  logic [15:0]     arch_code;
  logic [15:0]     model_code;
  logic            entry_logged_flag;
  logic            uncorrected_flag;
  logic            overflow_flag;
  logic            machine_check_enable_bit;
  logic            filter_enable;
  logic            strap_done;
  logic            strap_observe;
  logic            bi_sync1;
  logic            bi_sync2;
  logic            bi_sync3;
  logic            bi_level;
  logic            bi_prev;
  logic            bi_rise;
  logic            ext_event;
  logic            post_ok;
  logic            filter_act;
  logic            det_event;
  logic            new_uc;
  logic            take_event;
  logic [15:0]     next_code;
  logic [15:0]     next_model;
  logic [15:0]     enc_code;
  logic            f_bit;
  logic [1:0]      tt_fixed;
  logic [9:0]      iunc_low;
  mcece_form_type  enc_form;
  logic            apb_setup;
  logic            apb_commit;
  logic            wr_status;
  logic            wr_ctrl;
  logic            addr_hit;
  logic [31:0]     next_rdata;

  // ---------------------------------------------
  // strap capture and bus-init synchroniser
  // ---------------------------------------------
  // strap sampled on the first edge after reset release
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      strap_done    <= 1'b0;
      strap_observe <= 1'b0;
    end else if (!strap_done) begin
      strap_done    <= 1'b1;
      strap_observe <= strap_bus_init_observe_i;
    end
  end

  // three stages; level moves only when stages two and three agree
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bi_sync1 <= 1'b0;
      bi_sync2 <= 1'b0;
      bi_sync3 <= 1'b0;
      bi_level <= 1'b0;
      bi_prev  <= 1'b0;
    end else begin
      bi_sync1 <= bus_init_input_i;
      bi_sync2 <= bi_sync1;
      bi_sync3 <= bi_sync2;
      if (bi_sync2 == bi_sync3) begin
        bi_level <= bi_sync3;
      end
      bi_prev  <= bi_level;
    end
  end

  // ignored unless strapped and enabled
  assign bi_rise   = bi_level && !bi_prev;
  assign ext_event = bi_rise && strap_observe && machine_check_enable_bit; // see [RULE_09]

  // ---------------------------------------------
  // correction filtering
  // ---------------------------------------------
  // only corrected events train or consult the tracker
  mcece_line_filter u_filter (
    .core_clk_i   (core_clk_i),
    .rst_n_i      (rst_n_i),
    .corr_event_i (err_valid_i && !uncorrected_flag_i && filter_enable && !ext_event),
    .line_tag_i   (line_tag_i),
    .post_o       (post_ok),
    .filter_act_o (filter_act)
  );

  // suppressed corrections never reach the bank
  assign det_event = err_valid_i &&
                     (uncorrected_flag_i || !filter_enable || post_ok); // see [RULE_20] see [RULE_21]
  // set only for corrected postings that end posting
  assign f_bit     = !uncorrected_flag_i && filter_enable && filter_act; // see [RULE_18] see [RULE_19]

  // ---------------------------------------------
  // code encoder
  // ---------------------------------------------
  // reserved transaction kind folds to generic
  assign tt_fixed = (transaction_kind_field_i == `MCECE_TT_RSVD) ?
                    `MCECE_TT_GEN : transaction_kind_field_i; // see [RULE_23]
  // low part must not be zero
  assign iunc_low = (internal_detail_i == '0) ?
                    `MCECE_IUNC_LOW1 : internal_detail_i; // see [RULE_13]

  // class fully determined by the code value
  always_comb begin
    enc_form = MCECE_FORM_COMPOUND;
    enc_code = `MCECE_CODE_UNCL;
    unique case (err_class_i)
      MCECE_UNCLASSIFIED: begin
        enc_form = MCECE_FORM_SIMPLE;
        enc_code = `MCECE_CODE_UNCL; // see [RULE_06]
      end
      MCECE_UROM_PARITY: begin
        enc_form = MCECE_FORM_SIMPLE;
        enc_code = `MCECE_CODE_UROM; // see [RULE_07]
      end
      MCECE_LOCKSTEP: begin
        enc_form = MCECE_FORM_SIMPLE;
        enc_code = `MCECE_CODE_LOCK; // see [RULE_10]
      end
      MCECE_INT_PARITY: begin
        enc_form = MCECE_FORM_SIMPLE;
        enc_code = `MCECE_CODE_IPAR; // see [RULE_10]
      end
      MCECE_SMM_VIOLATION: begin
        enc_form = MCECE_FORM_SIMPLE;
        enc_code = `MCECE_CODE_SMM; // see [RULE_11]
      end
      MCECE_TIMER: begin
        enc_form = MCECE_FORM_SIMPLE;
        enc_code = `MCECE_CODE_TIMER; // see [RULE_12]
      end
      MCECE_IO: begin
        enc_form = MCECE_FORM_SIMPLE;
        enc_code = `MCECE_CODE_IO; // see [RULE_12]
      end
      MCECE_INT_UNCLASS: begin
        enc_form = MCECE_FORM_SIMPLE;
        enc_code = {`MCECE_IUNC_PFX, iunc_low}; // see [RULE_13]
      end
      MCECE_GEN_CACHE: begin
        enc_code = {`MCECE_TOP_ZERO, f_bit, `MCECE_GC_PFX,
                    hierarchy_level_field_i}; // see [RULE_14] see [RULE_24]
      end
      MCECE_TLB: begin
        enc_code = {`MCECE_TOP_ZERO, f_bit, `MCECE_TLB_PFX,
                    tt_fixed, hierarchy_level_field_i}; // see [RULE_15]
      end
      MCECE_CACHE: begin
        enc_code = {`MCECE_TOP_ZERO, f_bit, `MCECE_CH_PFX,
                    request_kind_field_i, tt_fixed,
                    hierarchy_level_field_i}; // see [RULE_15]
      end
      MCECE_MEM_CTRL: begin
        enc_code = {`MCECE_TOP_ZERO, f_bit, `MCECE_MC_PFX,
                    memory_request_field_i,
                    channel_number_field_i}; // see [RULE_16]
      end
      MCECE_EXT_MEM: begin
        enc_code = {`MCECE_TOP_ZERO, f_bit, `MCECE_XM_PFX,
                    memory_request_field_i,
                    channel_number_field_i}; // see [RULE_16]
      end
      MCECE_BUS: begin
        enc_code = {`MCECE_TOP_ZERO, f_bit, `MCECE_BUS_PFX,
                    participation_field_i, timeout_i,
                    request_kind_field_i, memory_or_io_field_i,
                    hierarchy_level_field_i}; // see [RULE_17]
      end
      default: begin
        // codes outside the enum log as unclassified
        enc_form = MCECE_FORM_SIMPLE;
        enc_code = `MCECE_CODE_UNCL; // see [RULE_06]
      end
    endcase
  end

  // ---------------------------------------------
  // bank update decision
  // ---------------------------------------------
  // external error wins a same-cycle detector event
  always_comb begin
    if (ext_event) begin
      next_code  = `MCECE_CODE_EXT; // see [RULE_08]
      next_model = '0;
      new_uc     = 1'b1;
    end else begin
      next_code  = enc_code; // see [RULE_03]
      next_model = model_code_i; // see [RULE_02]
      new_uc     = uncorrected_flag_i;
    end
  end

  // empty bank, or uncorrected replaces a corrected entry
  assign take_event = (ext_event || det_event) &&
                      (!entry_logged_flag || (new_uc && !uncorrected_flag));

  // ---------------------------------------------
  // apb decode
  // ---------------------------------------------
  // one wait state keeps read data registered
  assign apb_setup  = psel_i && penable_i && !pready_o;
  assign apb_commit = psel_i && penable_i && pready_o;
  assign wr_status  = apb_commit && pwrite_i && paddr_i == `MCECE_OFS_STATUS;
  assign wr_ctrl    = apb_commit && pwrite_i && paddr_i == `MCECE_OFS_CTRL;
  assign addr_hit   = paddr_i == `MCECE_OFS_STATUS || paddr_i == `MCECE_OFS_FLAGS ||
                      paddr_i == `MCECE_OFS_CTRL   || paddr_i == `MCECE_OFS_CAP;

  // read mux; reserved bits read zero
  always_comb begin
    next_rdata = '0;
    if (paddr_i == `MCECE_OFS_STATUS) begin
      next_rdata = {model_code, arch_code};
    end else if (paddr_i == `MCECE_OFS_FLAGS) begin
      next_rdata[`MCECE_FLG_VALID] = entry_logged_flag;
      next_rdata[`MCECE_FLG_UC]    = uncorrected_flag;
      next_rdata[`MCECE_FLG_OVER]  = overflow_flag;
    end else if (paddr_i == `MCECE_OFS_CTRL) begin
      next_rdata[`MCECE_CTL_MCE]  = machine_check_enable_bit;
      next_rdata[`MCECE_CTL_FILT] = filter_enable;
    end else if (paddr_i == `MCECE_OFS_CAP) begin
      next_rdata[`MCECE_CAP_FILT] = 1'b1; // see [RULE_20]
    end
  end

  // bus handshake outputs
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= '0;
    end else begin
      pready_o  <= apb_setup;
      pslverr_o <= apb_setup && !addr_hit;
      prdata_o  <= (apb_setup && !pwrite_i) ? next_rdata : '0;
    end
  end

  // control bits steer event handling
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      machine_check_enable_bit <= 1'b0;
      filter_enable            <= 1'b0;
    end else if (wr_ctrl) begin
      machine_check_enable_bit <= pwdata_i[`MCECE_CTL_MCE];
      filter_enable            <= pwdata_i[`MCECE_CTL_FILT];
    end
  end

  // ---------------------------------------------
  // error bank
  // ---------------------------------------------
  // code and flag written in one edge; new event beats clear
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      arch_code         <= `MCECE_CODE_NONE; // see [RULE_05]
      model_code        <= '0;
      entry_logged_flag <= 1'b0;
      uncorrected_flag  <= 1'b0;
    end else if (take_event) begin
      arch_code         <= next_code; // see [RULE_01] see [RULE_25]
      model_code        <= next_model;
      entry_logged_flag <= 1'b1; // see [RULE_01] see [RULE_25]
      uncorrected_flag  <= new_uc;
    end else if (wr_status) begin
      arch_code         <= `MCECE_CODE_NONE; // see [RULE_05]
      model_code        <= '0;
      entry_logged_flag <= 1'b0;
      uncorrected_flag  <= 1'b0;
    end
  end

  // any posted event while the bank is full, even one that replaces the entry
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      overflow_flag <= 1'b0;
    end else if ((ext_event || det_event) && entry_logged_flag) begin
      overflow_flag <= 1'b1;
    end else if (wr_status) begin
      overflow_flag <= 1'b0;
    end
  end

  // exception only for uncorrected entries while enabled
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mc_exception_o <= 1'b0;
    end else begin
      mc_exception_o <= take_event && new_uc && machine_check_enable_bit;
    end
  end
endmodule : mcece_encoder

// [rtl/mcece_defs.svh]
`ifndef MCECE_DEFS_SVH
`define MCECE_DEFS_SVH
// ---------------------------------------------
// register map (byte addresses)
// ---------------------------------------------
`define MCECE_ADDR_W        12
`define MCECE_OFS_STATUS    12'h000
`define MCECE_OFS_FLAGS     12'h004
`define MCECE_OFS_CTRL      12'h008
`define MCECE_OFS_CAP       12'h00C
// ---------------------------------------------
// field positions
// ---------------------------------------------
`define MCECE_FLG_VALID     0
`define MCECE_FLG_UC        1
`define MCECE_FLG_OVER      2
`define MCECE_CTL_MCE       0
`define MCECE_CTL_FILT      1
`define MCECE_CAP_FILT      11
`define MCECE_F_BIT         12
// ---------------------------------------------
// simple codes
// ---------------------------------------------
`define MCECE_CODE_NONE     16'h0000
`define MCECE_CODE_UNCL     16'h0001
`define MCECE_CODE_UROM     16'h0002
`define MCECE_CODE_EXT      16'h0003
`define MCECE_CODE_LOCK     16'h0004
`define MCECE_CODE_IPAR     16'h0005
`define MCECE_CODE_SMM      16'h0006
`define MCECE_CODE_TIMER    16'h0400
`define MCECE_CODE_IO       16'h0E0B
`define MCECE_IUNC_PFX      6'h01
`define MCECE_IUNC_LOW1     10'h001
// ---------------------------------------------
// compound prefixes and sub-field values
// ---------------------------------------------
`define MCECE_TOP_ZERO      3'h0
`define MCECE_GC_PFX        10'h003
`define MCECE_TLB_PFX       8'h01
`define MCECE_MC_PFX        5'h01
`define MCECE_CH_PFX        4'h1
`define MCECE_XM_PFX        5'h05
`define MCECE_BUS_PFX       1'h1
`define MCECE_TT_GEN        2'h2
`define MCECE_TT_RSVD       2'h3
// ---------------------------------------------
// correction filter sizing
// ---------------------------------------------
`define MCECE_TAG_W         8
`define MCECE_FLT_DEPTH     4
`define MCECE_FLT_IDX_W     2
`define MCECE_CNT_W         2
`define MCECE_FLT_THRESH    2'h3
`define MCECE_CNT_ONE       2'h1
`endif

// [rtl/mcece_pkg.sv]
package mcece_pkg;
  // detector error classes
  typedef enum logic [3:0] {
    MCECE_UNCLASSIFIED,
    MCECE_UROM_PARITY,
    MCECE_LOCKSTEP,
    MCECE_INT_PARITY,
    MCECE_SMM_VIOLATION,
    MCECE_TIMER,
    MCECE_IO,
    MCECE_INT_UNCLASS,
    MCECE_GEN_CACHE,
    MCECE_TLB,
    MCECE_MEM_CTRL,
    MCECE_CACHE,
    MCECE_EXT_MEM,
    MCECE_BUS
  } mcece_class_type;
  // compound codes carry the filter bit
  typedef enum logic [1:0] {
    MCECE_FORM_SIMPLE,
    MCECE_FORM_COMPOUND
  } mcece_form_type;
endpackage : mcece_pkg

// [rtl/mcece_line_filter.sv]
`timescale 1ns/1ps
`include "mcece_defs.svh"
module mcece_line_filter (
  input  wire logic                      core_clk_i,
  input  wire logic                      rst_n_i,
  input  wire logic                      corr_event_i,
  input  wire logic [`MCECE_TAG_W-1:0]   line_tag_i,
  output logic                           post_o,
  output logic                           filter_act_o
);
  logic [`MCECE_TAG_W-1:0]     tag_q  [`MCECE_FLT_DEPTH];
  logic [`MCECE_CNT_W-1:0]     cnt_q  [`MCECE_FLT_DEPTH];
  logic [`MCECE_FLT_DEPTH-1:0] used_q;
  logic [`MCECE_FLT_IDX_W-1:0] victim_q;
  logic                        hit;
  logic [`MCECE_FLT_IDX_W-1:0] hit_idx;
  logic [`MCECE_CNT_W-1:0]     hit_cnt;

  // ---------------------------------------------
  // lookup
  // ---------------------------------------------
  // tags are unique, so last match equals only match
  always_comb begin
    hit     = 1'b0;
    hit_idx = '0;
    for (int i = 0; i < `MCECE_FLT_DEPTH; i++) begin
      if (used_q[i] && tag_q[i] == line_tag_i) begin
        hit     = 1'b1;
        hit_idx = `MCECE_FLT_IDX_W'(i);
      end
    end
    hit_cnt      = cnt_q[hit_idx];
    post_o       = !hit || (hit_cnt < `MCECE_FLT_THRESH);
    filter_act_o = hit && (hit_cnt == `MCECE_FLT_THRESH - `MCECE_CNT_ONE);
  end

  // ---------------------------------------------
  // tracking
  // ---------------------------------------------
  // round-robin victim: a busy line may be evicted and re-posted
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      used_q   <= '0;
      victim_q <= '0;
      for (int i = 0; i < `MCECE_FLT_DEPTH; i++) begin
        tag_q[i] <= '0;
        cnt_q[i] <= '0;
      end
    end else if (corr_event_i) begin
      if (hit) begin
        if (hit_cnt < `MCECE_FLT_THRESH) begin
          cnt_q[hit_idx] <= hit_cnt + `MCECE_CNT_ONE;
        end
      end else begin
        tag_q[victim_q]  <= line_tag_i;
        cnt_q[victim_q]  <= `MCECE_CNT_ONE;
        used_q[victim_q] <= 1'b1;
        victim_q         <= victim_q + `MCECE_FLT_IDX_W'(1);
      end
    end
  end
endmodule : mcece_line_filter

// [tb/mcece_encoder_assertions.sv]
`timescale 1ns/1ps
`include "mcece_defs.svh"
module mcece_encoder_assertions (
  input wire logic                     core_clk_i,
  input wire logic                     rst_n_i,
  input wire logic                     psel_i,
  input wire logic                     penable_i,
  input wire logic                     pwrite_i,
  input wire logic [`MCECE_ADDR_W-1:0] paddr_i,
  input wire logic [31:0]              prdata_o,
  input wire logic                     pready_o,
  input wire logic                     pslverr_o,
  input wire logic                     err_valid_i,
  input wire logic                     uncorrected_flag_i,
  input wire logic                     bus_init_input_i,
  input wire logic                     mc_exception_o
);
  // ---------------------------------------------
  // bus answers and code shape
  // ---------------------------------------------
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  // access phase still waiting for its answer
  sequence s_access;
    psel_i && penable_i && !pready_o;
  endsequence
  sequence s_rd_status;
    s_access and (!pwrite_i && paddr_i == `MCECE_OFS_STATUS);
  endsequence
  a_ready_one_wait: assert property (s_access |=> pready_o)
    else $error("access not answered after one wait state");
  a_ready_pulse_once: assert property (pready_o |=> !pready_o)
    else $error("ready held longer than one cycle");
  a_idle_data_zero: assert property (!pready_o |-> prdata_o == 32'h0 && !pslverr_o)
    else $error("read data or error shown outside an answer");
  a_unmapped_refused: assert property ((s_access and (paddr_i > 12'h00C)) |=> pslverr_o && !prdata_o)
    else $error("unmapped access not refused");
  a_cap_filter_bit: assert property ((s_access and (!pwrite_i && paddr_i == `MCECE_OFS_CAP)) |=> prdata_o[11])
    else $error("filter capability bit clear");
  a_code_top_zero: assert property (s_rd_status |=> prdata_o[15:13] == 3'h0)
    else $error("code bits 15 to 13 not zero");
  a_iunc_low_nonzero: assert property (s_rd_status ##1 prdata_o[15:10] == 6'h01
    |-> prdata_o[9:0] != 10'h0 || prdata_o[15:0] == 16'h0400) // timer code shares the prefix
    else $error("internal unclassified code with zero low part");
  // an exception needs an uncorrected event or a held bus-init pin
  a_exc_has_cause: assert property (mc_exception_o |->
    ($past(err_valid_i) && $past(uncorrected_flag_i)) || $past(bus_init_input_i))
    else $error("exception without a cause");
endmodule : mcece_encoder_assertions

// [tb/mcece_handler_model.sv]
`timescale 1ns/1ps
`include "mcece_defs.svh"
module mcece_handler_model (
  input  wire logic                     core_clk_i,
  input  wire logic [31:0]              prdata_i,
  input  wire logic                     pready_i,
  input  wire logic                     pslverr_i,
  output logic                          psel_o,
  output logic                          penable_o,
  output logic                          pwrite_o,
  output logic [`MCECE_ADDR_W-1:0]      paddr_o,
  output logic [31:0]                   pwdata_o
);
  // ---------------------------------------------
  // apb master of the handler software
  // ---------------------------------------------
  // idle bus at time zero
  initial begin
    psel_o = 1'b0;
    penable_o = 1'b0;
    pwrite_o = 1'b0;
    paddr_o = '0;
    pwdata_o = '0;
  end
  // one transfer; waits for ready, watchdog bounds a hang
  task automatic xfer(input logic w, input logic [`MCECE_ADDR_W-1:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    @(posedge core_clk_i);
    psel_o <= 1'b1;
    penable_o <= 1'b0;
    pwrite_o <= w;
    paddr_o <= a;
    pwdata_o <= d;
    @(posedge core_clk_i);
    penable_o <= 1'b1;
    do @(posedge core_clk_i); while (pready_i !== 1'b1);
    q = prdata_i;
    e = pslverr_i;
    psel_o <= 1'b0;
    penable_o <= 1'b0;
    paddr_o <= ~a; // released lines do not keep the old value
    pwdata_o <= ~d;
  endtask : xfer
  // code field is only read from a bank that says it logged something
  task automatic read_bank(output logic [31:0] fl, output logic [31:0] st);
    logic e;
    xfer(1'b0, `MCECE_OFS_FLAGS, 32'h0, fl, e);
    st = 32'h0;
    if (fl[`MCECE_FLG_VALID] === 1'b1) begin
      xfer(1'b0, `MCECE_OFS_STATUS, 32'h0, st, e);
    end
  endtask : read_bank
endmodule : mcece_handler_model

// [tb/machine_check_error_code_encoder_tb.sv]
`timescale 1ns/1ps
`include "mcece_defs.svh"
module machine_check_error_code_encoder_tb
  import mcece_pkg::*;
;
  // ---------------------------------------------
  // stimulus and checking
  // ---------------------------------------------
  logic                     clk = 1'b0;
  logic                     rst_n, psel, penable, pwrite, pready, pslverr;
  logic                     ev_valid, uc, tmo, bus_init_input, strap, exc;
  logic [`MCECE_ADDR_W-1:0] paddr;
  logic [31:0]              pwdata, prdata;
  logic [7:0]               tag;
  logic [1:0]               tt, ll, pp, ii;
  logic [3:0]               rk, ch;
  logic [2:0]               mm;
  logic [9:0]               idet;
  logic [15:0]              mcode;
  mcece_class_type          cls;
  int                       err_count, total_checks;
  // 25 MHz core clock
  always #20 clk = ~clk;
  mcece_encoder dut_u (.core_clk_i(clk), .rst_n_i(rst_n), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .err_valid_i(ev_valid), .err_class_i(cls), .uncorrected_flag_i(uc),
    .line_tag_i(tag), .transaction_kind_field_i(tt), .hierarchy_level_field_i(ll),
    .request_kind_field_i(rk), .memory_request_field_i(mm), .channel_number_field_i(ch),
    .participation_field_i(pp), .timeout_i(tmo), .memory_or_io_field_i(ii), .internal_detail_i(idet),
    .model_code_i(mcode), .bus_init_input_i(bus_init_input), .strap_bus_init_observe_i(strap),
    .mc_exception_o(exc));
  mcece_handler_model hnd_u (.core_clk_i(clk), .prdata_i(prdata), .pready_i(pready),
    .pslverr_i(pslverr), .psel_o(psel), .penable_o(penable), .pwrite_o(pwrite),
    .paddr_o(paddr), .pwdata_o(pwdata));
  task automatic close_out;
    $display("checks %0d, mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : close_out
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0d ns: got %h, expected %h", $time, got, exp);
    end
  endtask : chk
  // one-cycle detector pulse
  task automatic fire(input mcece_class_type c, input logic u);
    @(posedge clk);
    ev_valid <= 1'b1;
    cls <= c;
    uc <= u;
    @(posedge clk);
    ev_valid <= 1'b0;
  endtask : fire
  // judge the bank, then clear it for the next event
  task automatic bank(input logic [15:0] code, input logic [2:0] fl);
    logic [31:0] f, s;
    logic        e;
    hnd_u.read_bank(f, s);
    chk(f, {29'h0, fl});
    chk(s, fl[0] ? {(code == 16'h0003) ? 16'h0 : mcode, code} : 32'h0); // bus-init stores no model code
    hnd_u.xfer(1'b1, `MCECE_OFS_STATUS, 32'h0, s, e);
  endtask : bank
  task automatic case1(input mcece_class_type c, input logic [15:0] code);
    fire(c, 1'b0);
    bank(code, 3'b001);
  endtask : case1
  task automatic t_reset;
    logic [31:0] q;
    logic        e;
    hnd_u.xfer(1'b0, `MCECE_OFS_STATUS, 32'h0, q, e);
    chk(q, 32'h0);
    hnd_u.xfer(1'b0, `MCECE_OFS_CAP, 32'h0, q, e);
    chk(q & 32'h0000_0800, 32'h0000_0800);
    hnd_u.xfer(1'b0, 12'h010, 32'h0, q, e);
    chk({q[30:0], e}, 32'h1);
  endtask : t_reset
  task automatic t_codes;
    case1(MCECE_UNCLASSIFIED, 16'h0001);
    case1(MCECE_UROM_PARITY, 16'h0002);
    case1(MCECE_LOCKSTEP, 16'h0004);
    case1(MCECE_INT_PARITY, 16'h0005);
    case1(MCECE_SMM_VIOLATION, 16'h0006);
    case1(MCECE_TIMER, 16'h0400);
    case1(MCECE_IO, 16'h0E0B);
    case1(MCECE_INT_UNCLASS, 16'h0555);
    idet <= 10'h000;
    case1(MCECE_INT_UNCLASS, 16'h0401);
    case1(MCECE_GEN_CACHE, 16'h000E);
    case1(MCECE_CACHE, 16'h0136);
    case1(MCECE_MEM_CTRL, 16'h00C5);
    case1(MCECE_EXT_MEM, 16'h02C5);
    case1(MCECE_BUS, 16'h0D3A);
    // every kind and level; kind 11 falls back to generic
    for (int i = 0; i < 4; i++) begin
      tt <= 2'(i);
      ll <= 2'(i);
      case1(MCECE_TLB, {12'h001, (i == 3) ? 2'h2 : 2'(i), 2'(i)});
    end
    {tt, ll} <= {2'h1, 2'h2};
  endtask : t_codes
  task automatic t_filter;
    logic [31:0] q;
    logic        e;
    hnd_u.xfer(1'b1, `MCECE_OFS_CTRL, 32'h2, q, e);
    tag <= 8'h3C;
    for (int i = 1; i <= 3; i++) begin
      fire(MCECE_CACHE, 1'b0);
      bank((i == 3) ? 16'h1136 : 16'h0136, 3'b001);
    end
    fire(MCECE_CACHE, 1'b0);
    bank(16'h0, 3'b000);
    fire(MCECE_CACHE, 1'b1);
    bank(16'h0136, 3'b011);
    hnd_u.xfer(1'b1, `MCECE_OFS_CTRL, 32'h0, q, e);
  endtask : t_filter
  // pin held past the synchroniser; exception only if enabled
  task automatic t_bus_init_input;
    logic [31:0] q;
    logic        e;
    int          n;
    for (int m = 1; m >= 0; m--) begin
      hnd_u.xfer(1'b1, `MCECE_OFS_CTRL, 32'(m), q, e);
      n = 0;
      bus_init_input <= 1'b1;
      repeat (20) begin
        @(negedge clk);
        if (exc === 1'b1) n++;
      end
      @(posedge clk);
      bus_init_input <= 1'b0;
      chk(32'(n), 32'(m));
      bank((m == 1) ? 16'h0003 : 16'h0, (m == 1) ? 3'b011 : 3'b000);
    end
  endtask : t_bus_init_input
  // main sequence
  initial begin
    rst_n = 1'b0;
    ev_valid = 1'b0;
    cls = MCECE_UNCLASSIFIED;
    uc = 1'b0;
    tag = 8'h00;
    {tt, ll, rk, mm, ch} = {2'h1, 2'h2, 4'h3, 3'h4, 4'h5};
    {pp, tmo, ii} = {2'h2, 1'b1, 2'h2};
    idet = 10'h155;
    mcode = 16'hA5A5;
    bus_init_input = 1'b0;
    strap = 1'b1;
    err_count = 0;
    total_checks = 0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    t_reset;
    t_codes;
    t_filter;
    t_bus_init_input;
    close_out;
  end
  // watchdog far beyond the run length
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    close_out;
  end
endmodule : machine_check_error_code_encoder_tb
bind mcece_encoder mcece_encoder_assertions chk_u (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
  .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .prdata_o(prdata_o),
  .pready_o(pready_o), .pslverr_o(pslverr_o), .err_valid_i(err_valid_i),
  .uncorrected_flag_i(uncorrected_flag_i), .bus_init_input_i(bus_init_input_i),
  .mc_exception_o(mc_exception_o));
